// ---- rtl/cwg_pkg.sv ----
// Constants shared by the waveform generator control register block.
// Assumes an APB master with 32-bit data; registers sit in the low byte.
// What this block does
// RL1 - Enable bit 7 of control 0 turns the generator on or off.
// RL2 - Load request copies buffered settings on the next edge, then clears.
// RL3 - Load request sets only when already enabled, not with enable itself.
// RL4 - Mode field selects steering, sync steering, full, half or push-pull.
// RL5 - Polarity bits 0 to 3 invert outputs A to D when set.
// RL6 - Six-bit rising dead-band count, kept across resets.
// RL7 - Six-bit falling dead-band count, kept across resets.
// RL8 - Shutdown status reads 1 in shutdown; hardware sets it, software too.
// RL9 - Auto-restart bit selects automatic or software recovery.
// RL10 - In shutdown outputs B and D follow their two-bit override field.
// RL11 - In shutdown outputs A and C follow their two-bit override field.
// RL12 - Shutdown written while disabled places outputs at override levels.
// RL13 - After shutdown clears, overrides hold until next input rising edge.
// RL14 - Seven fault-source enables let each source trigger shutdown.
// RL15 - Bit 7 of the fault-source enable register always reads 1.
// RL16 - Other unimplemented bits ignore writes and read 0.
// RL17 - Fault sources are active-low levels; active enabled ones block clearing.
// RL18 - With auto-restart, shutdown clears itself once sources go inactive.
// RL19 - Without auto-restart, software clear fails while a source is active.
// RL20 - Steering changes act at once in mode 000, at input rise in 001.
// RL21 - In half-bridge mode dead-band delays rising and falling transitions by the counts; push-pull uses the rising count only.
package cwg_pkg;
  localparam logic [7:0] OFS_CON0 = 8'h00;
  localparam logic [7:0] OFS_CON1 = 8'h04;
  localparam logic [7:0] OFS_DBR  = 8'h08;
  localparam logic [7:0] OFS_DBF  = 8'h0C;
  localparam logic [7:0] OFS_AS0  = 8'h10;
  localparam logic [7:0] OFS_AS1  = 8'h14;
  localparam int BIT_EN   = 7;
  localparam int BIT_LD   = 6;
  localparam int BIT_IN   = 5;
  localparam int BIT_SD   = 7;
  localparam int BIT_REN  = 6;
  localparam int OVERRIDE_LEVEL_B_D_LSB = 4;
  localparam int OVERRIDE_LEVEL_A_C_LSB = 2;
  localparam logic [1:0] RST_OVERRIDE_LEVEL_B_D = 2'h1;
  localparam logic [1:0] RST_OVERRIDE_LEVEL_A_C = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  localparam logic [1:0] LVL_LOW  = 2'h2;
  localparam logic [1:0] LVL_TRI  = 2'h1;
  localparam logic [1:0] LVL_IDLE = 2'h0;
  localparam logic [7:0] AS1_FIXED = 8'h80;
  localparam int DB_W  = 6;
  localparam int SRC_N = 7;
  typedef enum logic [2:0] {
    CWG_STEER, CWG_SYNC_STEER, CWG_FWD, CWG_REV,
    CWG_HALF, CWG_PUSH_PULL, CWG_RSV6, CWG_RSV7
  } cwg_mode_t;
endpackage

// ---- rtl/cwg_ctrl_regs.sv ----
// Control, dead-band and auto-shutdown registers of a four-output
// complementary waveform generator, with the output stage they steer.
// Assumes a single 20 MHz core_clk, synchronous inputs and an APB master.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module cwg_ctrl_regs
  import cwg_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Input waveform and steering controls
  input  wire logic              data_in,
  input  wire logic [3:0]        steer_enable,
  input  wire logic [3:0]        steer_value,
  // Fault sources, active low
  input  wire logic              input_pin_select,
  input  wire logic              timer2_fault_n,
  input  wire logic              timer4_fault_n,
  input  wire logic              timer6_fault_n,
  input  wire logic              comparator1_fault_n,
  input  wire logic              comparator2_fault_n,
  input  wire logic              logic_cell2_output,
  // Outputs and their enables, enable low while driving
  output logic                   output_a,
  output logic                   output_b,
  output logic                   output_c,
  output logic                   output_d,
  output logic                   output_a_oe_n,
  output logic                   output_b_oe_n,
  output logic                   output_c_oe_n,
  output logic                   output_d_oe_n
);

  // Register state
  logic            en_r, en_nxt;
  logic            ld_r, ld_nxt;
  cwg_mode_t       mode_r, mode_nxt;
  logic [3:0]      pol_r, pol_nxt;
  logic [DB_W-1:0] dbr_r, dbr_nxt;
  logic [DB_W-1:0] dbf_r, dbf_nxt;
  logic            sd_r, sd_nxt;
  logic            ren_r, ren_nxt;
  logic [1:0]      override_level_b_d_r, override_level_b_d_nxt;
  logic [1:0]      override_level_a_c_r, override_level_a_c_nxt;
  logic [SRC_N-1:0] src_en_r, src_en_nxt;
  // APB answer
  logic [31:0]     rdata_r, rdata_nxt;
  logic            rdy_r, rdy_nxt;
  logic            err_r, err_nxt;
  // Waveform state
  logic            data_d_r;
  logic [DB_W-1:0] cnt_r, cnt_nxt;
  logic [DB_W-1:0] dbr_act_r, dbr_act_nxt;
  logic [DB_W-1:0] dbf_act_r, dbf_act_nxt;
  logic            hold_r, hold_nxt;
  logic            pp_r, pp_nxt;
  logic [3:0]      str_en_r, str_en_nxt;
  logic [3:0]      str_val_r, str_val_nxt;
  logic [3:0]      out_r, out_nxt;
  logic [3:0]      oe_n_r, oe_n_nxt;
  // Decode
  logic            setup, wr, mapped;
  logic            wr_con0, wr_con1, wr_dbr, wr_dbf, wr_as0, wr_as1;
  logic [7:0]      wb;
  logic [SRC_N-1:0] src_act;
  logic            fault_act;
  logic            rise, fall, evt;
  logic [DB_W-1:0] cnt_eff;
  logic            pri, sec;
  logic [3:0]      wave, s_en, s_val;
  logic            ovr_act, steer_md;

  assign setup   = psel && !penable;
  assign wr      = psel && penable && rdy_r && pwrite;
  assign wb      = pwdata[7:0];
  assign mapped  = (paddr == ADDR_W'(OFS_CON0)) ||
                   (paddr == ADDR_W'(OFS_CON1)) ||
                   (paddr == ADDR_W'(OFS_DBR))  ||
                   (paddr == ADDR_W'(OFS_DBF))  ||
                   (paddr == ADDR_W'(OFS_AS0))  ||
                   (paddr == ADDR_W'(OFS_AS1));
  assign wr_con0 = wr && (paddr == ADDR_W'(OFS_CON0));
  assign wr_con1 = wr && (paddr == ADDR_W'(OFS_CON1));
  assign wr_dbr  = wr && (paddr == ADDR_W'(OFS_DBR));
  assign wr_dbf  = wr && (paddr == ADDR_W'(OFS_DBF));
  assign wr_as0  = wr && (paddr == ADDR_W'(OFS_AS0));
  assign wr_as1  = wr && (paddr == ADDR_W'(OFS_AS1));

  // Sources are active low; bit order follows the enable register
  assign src_act = ~{logic_cell2_output, comparator2_fault_n,
                     comparator1_fault_n, timer6_fault_n,
                     timer4_fault_n, timer2_fault_n, input_pin_select};
  assign fault_act = |(src_act & src_en_r); // RL14 RL17

  assign rise = data_in && !data_d_r;
  assign fall = !data_in && data_d_r;
  assign evt  = rise || fall;

  // Register file
  always_comb
  begin
    en_nxt     = en_r;
    ld_nxt     = ld_r;
    mode_nxt   = mode_r;
    pol_nxt    = pol_r;
    dbr_nxt    = dbr_r;
    dbf_nxt    = dbf_r;
    sd_nxt     = sd_r;
    ren_nxt    = ren_r;
    override_level_b_d_nxt   = override_level_b_d_r;
    override_level_a_c_nxt   = override_level_a_c_r;
    src_en_nxt = src_en_r;
    if (wr_con0)
    begin
      en_nxt   = wb[BIT_EN]; // RL1
      mode_nxt = cwg_mode_t'(wb[2:0]); // RL4
    end
    if (ld_r && evt)
      ld_nxt = 1'b0; // RL2
    // Only an already enabled block takes a load request
    if (wr_con0 && wb[BIT_LD] && en_r)
      ld_nxt = 1'b1; // RL3
    if (!en_nxt)
      ld_nxt = 1'b0;
    if (wr_con1)
      pol_nxt = wb[3:0]; // RL5 RL16
    if (wr_dbr)
      dbr_nxt = wb[DB_W-1:0]; // RL6
    if (wr_dbf)
      dbf_nxt = wb[DB_W-1:0]; // RL7
    if (wr_as0)
    begin
      ren_nxt  = wb[BIT_REN]; // RL9
      override_level_b_d_nxt = wb[OVERRIDE_LEVEL_B_D_LSB+:2];
      override_level_a_c_nxt = wb[OVERRIDE_LEVEL_A_C_LSB+:2];
      // A clear is refused while a selected source is active
      if (wb[BIT_SD] || !fault_act)
        sd_nxt = wb[BIT_SD]; // RL12 RL19
    end
    if (ren_r && sd_r && !fault_act && !wr_as0)
      sd_nxt = 1'b0; // RL18
    // Hardware set wins over any clear in the same cycle
    if (fault_act)
      sd_nxt = 1'b1; // RL8 RL17
    if (wr_as1)
      src_en_nxt = wb[SRC_N-1:0]; // RL14
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      en_r     <= 1'b0;
      ld_r     <= 1'b0;
      mode_r   <= CWG_STEER;
      pol_r    <= 4'h0;
      sd_r     <= 1'b0;
      ren_r    <= 1'b0;
      override_level_b_d_r   <= RST_OVERRIDE_LEVEL_B_D;
      override_level_a_c_r   <= RST_OVERRIDE_LEVEL_A_C;
      src_en_r <= 7'h00;
    end
    else
    begin
      en_r     <= en_nxt;
      ld_r     <= ld_nxt;
      mode_r   <= mode_nxt;
      pol_r    <= pol_nxt;
      sd_r     <= sd_nxt;
      ren_r    <= ren_nxt;
      override_level_b_d_r   <= override_level_b_d_nxt;
      override_level_a_c_r   <= override_level_a_c_nxt;
      src_en_r <= src_en_nxt;
    end
  end

  // Dead-band counts survive reset, so they take no reset term
  always_ff @(posedge core_clk)
  begin
    dbr_r <= dbr_nxt; // RL6
    dbf_r <= dbf_nxt; // RL7
  end

  // APB answer: data is fetched in setup, pready is high in access
  always_comb
  begin
    rdy_nxt   = setup;
    err_nxt   = setup && !mapped;
    rdata_nxt = rdata_r;
    if (setup)
    begin
      rdata_nxt = 32'h0000_0000; // RL16
      if (paddr == ADDR_W'(OFS_CON0))
        rdata_nxt[7:0] = {en_r, ld_r, 3'h0, mode_r};
      else if (paddr == ADDR_W'(OFS_CON1))
        rdata_nxt[7:0] = {2'h0, data_in, 1'b0, pol_r};
      else if (paddr == ADDR_W'(OFS_DBR))
        rdata_nxt[7:0] = {2'h0, dbr_r};
      else if (paddr == ADDR_W'(OFS_DBF))
        rdata_nxt[7:0] = {2'h0, dbf_r};
      else if (paddr == ADDR_W'(OFS_AS0))
        rdata_nxt[7:0] = {sd_r, ren_r, override_level_b_d_r, override_level_a_c_r, 2'h0}; // RL8
      else if (paddr == ADDR_W'(OFS_AS1))
        rdata_nxt[7:0] = AS1_FIXED | {1'b0, src_en_r}; // RL15
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rdata_r <= 32'h0000_0000;
      rdy_r   <= 1'b0;
      err_r   <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rdy_r   <= rdy_nxt;
      err_r   <= err_nxt;
    end
  end

  // Waveform shaping; outputs lag the input by one extra cycle
  assign cnt_eff = evt ? {DB_W{1'b0}} : cnt_r;
  assign pri = data_in && (cnt_eff >= dbr_act_r); // RL21
  assign sec = !data_in && (cnt_eff >= dbf_act_r); // RL21
  assign steer_md = (mode_r == CWG_STEER) || (mode_r == CWG_SYNC_STEER);
  assign ovr_act = sd_r || hold_r;
  assign s_en  = (mode_r == CWG_SYNC_STEER) ? str_en_r : steer_enable;
  assign s_val = (mode_r == CWG_SYNC_STEER) ? str_val_r : steer_value;

  always_comb
  begin
    cnt_nxt     = cnt_r;
    dbr_act_nxt = dbr_act_r;
    dbf_act_nxt = dbf_act_r;
    hold_nxt    = hold_r;
    pp_nxt      = pp_r;
    str_en_nxt  = str_en_r;
    str_val_nxt = str_val_r;
    if (cnt_eff != {DB_W{1'b1}})
      cnt_nxt = cnt_eff + 1'b1;
    else
      cnt_nxt = cnt_eff;
    // Disabled block tracks the buffers; enabled one waits for a load
    if (!en_r || (ld_r && evt))
    begin
      dbr_act_nxt = dbr_r; // RL2
      dbf_act_nxt = dbf_r;
    end
    if (rise)
      pp_nxt = !pp_r;
    if (rise || mode_r != CWG_SYNC_STEER)
    begin
      str_en_nxt  = steer_enable; // RL20
      str_val_nxt = steer_value;
    end
    // Overrides linger after a clear until the next input rise
    if (sd_r)
      hold_nxt = 1'b1;
    else if (rise)
      hold_nxt = 1'b0; // RL13
  end

  always_comb
  begin
    wave     = 4'h0;
    out_nxt  = 4'h0;
    oe_n_nxt = 4'hF;
    unique case (mode_r)
      CWG_STEER, CWG_SYNC_STEER:
        wave = 4'h0;
      CWG_FWD:
        wave = {data_in, 1'b0, 1'b0, 1'b1};
      CWG_REV:
        wave = {1'b0, 1'b1, data_in, 1'b0};
      CWG_HALF:
        wave = {sec, pri, sec, pri};
      CWG_PUSH_PULL:
        wave = {pri && !pp_r, pri && pp_r, pri && !pp_r, pri && pp_r};
      default:
        wave = 4'h0;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      if (en_r)
      begin
        oe_n_nxt[i] = 1'b0; // RL1
        if (steer_md)
          out_nxt[i] = s_en[i] ? (data_in ^ pol_r[i]) : s_val[i];
        else
          out_nxt[i] = wave[i] ^ pol_r[i]; // RL5
      end
      // Steered-off pins keep their fixed level in shutdown
      if (ovr_act && (!en_r || !steer_md || s_en[i]))
      begin
        unique case ((i % 2 == 1) ? override_level_b_d_r : override_level_a_c_r) // RL10 RL11
          LVL_HIGH:
          begin
            out_nxt[i]  = 1'b1;
            oe_n_nxt[i] = 1'b0;
          end
          LVL_LOW:
          begin
            out_nxt[i]  = 1'b0;
            oe_n_nxt[i] = 1'b0;
          end
          LVL_TRI:
          begin
            out_nxt[i]  = 1'b0;
            oe_n_nxt[i] = 1'b1;
          end
          LVL_IDLE:
          begin
            out_nxt[i]  = pol_r[i];
            oe_n_nxt[i] = 1'b0; // RL12
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      data_d_r  <= 1'b0;
      cnt_r     <= {DB_W{1'b0}};
      dbr_act_r <= {DB_W{1'b0}};
      dbf_act_r <= {DB_W{1'b0}};
      hold_r    <= 1'b0;
      pp_r      <= 1'b0;
      str_en_r  <= 4'h0;
      str_val_r <= 4'h0;
      out_r     <= 4'h0;
      oe_n_r    <= 4'hF;
    end
    else
    begin
      data_d_r  <= data_in;
      cnt_r     <= cnt_nxt;
      dbr_act_r <= dbr_act_nxt;
      dbf_act_r <= dbf_act_nxt;
      hold_r    <= hold_nxt;
      pp_r      <= pp_nxt;
      str_en_r  <= str_en_nxt;
      str_val_r <= str_val_nxt;
      out_r     <= out_nxt;
      oe_n_r    <= oe_n_nxt;
    end
  end

  assign prdata        = rdata_r;
  assign pready        = rdy_r;
  assign pslverr       = err_r;
  assign output_a      = out_r[0];
  assign output_b      = out_r[1];
  assign output_c      = out_r[2];
  assign output_d      = out_r[3];
  assign output_a_oe_n = oe_n_r[0];
  assign output_b_oe_n = oe_n_r[1];
  assign output_c_oe_n = oe_n_r[2];
  assign output_d_oe_n = oe_n_r[3];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_sd_falls;
    sd_r ##1 !sd_r;
  endsequence

  a_ld_needs_en: assert property ( // RL3
    $rose(ld_r) |-> $past(en_r))
    else $error("load request set while not enabled");
  a_ld_clears: assert property ( // RL2
    ld_r && evt && en_r && !wr_con0 |=> !ld_r)
    else $error("load request not cleared after event");
  a_fault_sets: assert property ( // RL8
    fault_act |=> sd_r)
    else $error("fault did not set shutdown");
  a_sw_clr_blocked: assert property ( // RL19
    wr_as0 && !wb[BIT_SD] && fault_act |=> sd_r ##1 sd_r || fault_act)
    else $error("shutdown cleared while fault active");
  a_auto_restart: assert property ( // RL18
    ren_r && sd_r && !fault_act && !wr_as0 |=> !sd_r)
    else $error("auto restart did not clear shutdown");
  a_hold_until_rise: assert property ( // RL13
    s_sd_falls ##0 !rise |=> hold_r)
    else $error("override released before input rise");
  a_ac_tristate: assert property ( // RL11
    sd_r && override_level_a_c_r == LVL_TRI && !steer_md |=> output_a_oe_n
      && output_c_oe_n)
    else $error("A/C not tri-stated in shutdown");
  a_bd_high: assert property ( // RL10
    sd_r && override_level_b_d_r == LVL_HIGH && !steer_md |=> output_b && output_d
      && !output_b_oe_n && !output_d_oe_n)
    else $error("B/D not high in shutdown");
  a_as1_top_bit: assert property ( // RL15
    setup && paddr == ADDR_W'(OFS_AS1) |=> prdata[7])
    else $error("fault enable bit 7 not read as one");
  a_off_released: assert property ( // RL1
    !en_r && !ovr_act |=> output_a_oe_n && output_b_oe_n
      && output_c_oe_n && output_d_oe_n)
    else $error("disabled block drives outputs");

endmodule // cwg_ctrl_regs

// ---- tb/cwg_bridge_model.sv ----
// Behavioural model of the external bridge driver stages on four pins.
// Assumes the generator drives levels with active-low drive enables.
`timescale 1ns/1ns
module cwg_bridge_model (
  // Clock
  input  wire logic       core_clk,
  // Generator side
  input  wire logic [3:0] drv_level,
  input  wire logic [3:0] drv_oe_n,
  // Resolved pin levels
  output logic [3:0]      pin_level
);
  logic [3:0] last_r;

  always_ff @(posedge core_clk)
  begin
    last_r <= pin_level;
  end

  // A released pin floats: show a toggling level so a stale value
  // never passes for a driven one
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pin_level[i] = drv_oe_n[i] ? ~last_r[i] : drv_level[i];
    end
  end
endmodule // cwg_bridge_model

// ---- tb/cwg_ctrl_regs_tb.sv ----
// Self-checking bench for the generator control register block.
// Assumes APB access with one wait-free access cycle and a 20 MHz clock.
`timescale 1ns/1ns
module cwg_ctrl_regs_tb;
  import cwg_pkg::*;
  logic        core_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        data_in;
  logic [3:0]  steer_enable;
  logic [3:0]  steer_value;
  logic [6:0]  src_n;
  logic [3:0]  pins_out;
  logic [3:0]  pins_oe_n;
  logic [3:0]  pin_level;
  logic [31:0] rdata;
  logic        rerr;
  int          errors;
  int          checked;
  int          cycles;

  cwg_ctrl_regs u_cwg_ctrl_regs (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_in(data_in),
    .steer_enable(steer_enable), .steer_value(steer_value),
    .input_pin_select(src_n[0]), .timer2_fault_n(src_n[1]),
    .timer4_fault_n(src_n[2]), .timer6_fault_n(src_n[3]),
    .comparator1_fault_n(src_n[4]), .comparator2_fault_n(src_n[5]),
    .logic_cell2_output(src_n[6]),
    .output_a(pins_out[0]), .output_b(pins_out[1]),
    .output_c(pins_out[2]), .output_d(pins_out[3]),
    .output_a_oe_n(pins_oe_n[0]), .output_b_oe_n(pins_oe_n[1]),
    .output_c_oe_n(pins_oe_n[2]), .output_d_oe_n(pins_oe_n[3])
  );

  cwg_bridge_model u_cwg_bridge_model (
    .core_clk(core_clk), .drv_level(pins_out), .drv_oe_n(pins_oe_n),
    .pin_level(pin_level)
  );

  always #25 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rdata, {24'h0, e});
  endtask

  // Pins settle one register stage after their cause
  task automatic pins(input logic [3:0] eo, input logic [3:0] eoe);
    repeat (4) @(posedge core_clk);
    chk("oe_n", {28'h0, pins_oe_n}, {28'h0, eoe});
    if (eoe === 4'h0)
      chk("pins", {28'h0, pin_level}, {28'h0, eo});
  endtask

  task automatic pulse();
    @(posedge core_clk);
    data_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    data_in <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  initial
  begin
    logic [1:0] c;
    core_clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; data_in = 1'b0;
    steer_enable = 4'h0; steer_value = 4'h0; src_n = 7'h7F;
    errors = 0; checked = 0; cycles = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd("con0", OFS_CON0, 8'h00);
    rd("con1", OFS_CON1, 8'h00);
    rd("as0", OFS_AS0, 8'h14);
    rd("as1", OFS_AS1, 8'h80);
    $display("test reset values done");
    wr(OFS_CON0, 8'hFF);
    rd("con0", OFS_CON0, 8'h87);
    wr(OFS_CON0, 8'h00);
    wr(OFS_CON1, 8'hFF);
    rd("con1", OFS_CON1, 8'h0F);
    wr(OFS_DBR, 8'hFF);
    rd("dbr", OFS_DBR, 8'h3F);
    wr(OFS_DBF, 8'hFF);
    rd("dbf", OFS_DBF, 8'h3F);
    wr(OFS_AS0, 8'h3F);
    rd("as0", OFS_AS0, 8'h3C);
    wr(OFS_AS1, 8'h00);
    rd("as1", OFS_AS1, 8'h80);
    apb(1'b0, 8'h18, 8'h00);
    chk("unmapped data", rdata, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    for (int m = 0; m < 8; m++)
    begin
      wr(OFS_CON0, 8'(m));
      rd("mode", OFS_CON0, 8'(m));
    end
    $display("test register fields done");
    wr(OFS_DBR, 8'h15);
    wr(OFS_DBF, 8'h2A);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd("dbr kept", OFS_DBR, 8'h15);
    rd("dbf kept", OFS_DBF, 8'h2A);
    rd("as0 reset", OFS_AS0, 8'h14);
    wr(OFS_DBR, 8'h00);
    wr(OFS_DBF, 8'h00);
    $display("test dead-band retention done");
    wr(OFS_CON0, 8'h02);
    for (int k = 1; k < 4; k++)
    begin
      c = k[1:0];
      wr(OFS_AS0, {2'b10, c, c, 2'b00});
      pins((c == LVL_HIGH) ? 4'hF : 4'h0,
           (c == LVL_TRI) ? 4'hF : 4'h0);
    end
    wr(OFS_AS0, 8'hB8);
    pins(4'hA, 4'h0);
    wr(OFS_CON1, 8'h05);
    wr(OFS_AS0, 8'h80);
    pins(4'h5, 4'h0);
    wr(OFS_CON1, 8'h00);
    wr(OFS_AS0, 8'h38);
    // Overrides linger after the clear until an input rise
    pins(4'hA, 4'h0);
    pulse();
    pins(4'h0, 4'hF);
    $display("test override levels done");
    wr(OFS_CON0, 8'h82);
    pulse();
    pins(4'h1, 4'h0);
    wr(OFS_CON1, 8'h0F);
    pins(4'hE, 4'h0);
    wr(OFS_CON1, 8'h00);
    // Load request only after enable is already set
    wr(OFS_CON0, 8'hC2);
    rd("load set", OFS_CON0, 8'hC2);
    pulse();
    rd("load clear", OFS_CON0, 8'h82);
    $display("test enable and load done");
    for (int k = 0; k < 7; k++)
    begin
      wr(OFS_AS1, 8'(1 << k));
      @(posedge core_clk);
      src_n[k] <= 1'b0;
      pins(4'hA, 4'h0);
      rd("sd set", OFS_AS0, 8'hB8);
      wr(OFS_AS0, 8'h38);
      rd("sd held", OFS_AS0, 8'hB8);
      @(posedge core_clk);
      src_n <= 7'h7F;
      wr(OFS_AS0, 8'h38);
      rd("sd cleared", OFS_AS0, 8'h38);
      pins(4'hA, 4'h0);
      @(posedge core_clk);
      data_in <= 1'b1;
      pins(4'h9, 4'h0);
      data_in <= 1'b0;
    end
    $display("test fault sources done");
    wr(OFS_AS1, 8'h01);
    wr(OFS_AS0, 8'h78);
    @(posedge core_clk);
    src_n[0] <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd("auto sd", OFS_AS0, 8'hF8);
    @(posedge core_clk);
    src_n <= 7'h7F;
    repeat (3) @(posedge core_clk);
    rd("auto clear", OFS_AS0, 8'h78);
    $display("test auto restart done");
    pulse();
    wr(OFS_CON0, 8'h83);
    pins(4'h4, 4'h0);
    wr(OFS_CON0, 8'h84);
    pins(4'hA, 4'h0);
    @(posedge core_clk);
    steer_value <= 4'h5;
    wr(OFS_CON0, 8'h80);
    pins(4'h5, 4'h0);
    $display("test other modes done");
    print_verdict();
  end
endmodule // cwg_ctrl_regs_tb
